// ### design/iets_defines.svh
`ifndef IETS_DEFINES_SVH
`define IETS_DEFINES_SVH

// Clock and microsecond timing
`define IETS_CLK_NS      10
`define IETS_US_NS       1000
`define IETS_US_CYCLES   (`IETS_US_NS / `IETS_CLK_NS)

// Capture area geometry
`define IETS_N_CH        4
`define IETS_N_SMALL     5
`define IETS_N_LARGE     15
`define IETS_ENTRY_BYTES 4
`define IETS_N_FIELDS    3

// Byte offsets inside one entry
`define IETS_OFS_STATE   2'h0
`define IETS_OFS_SEQ     2'h1
`define IETS_OFS_TS_LO   2'h2
`define IETS_OFS_TS_HI   2'h3

// Sequence counter values
`define IETS_SEQ_FIRST   7'h01
`define IETS_SEQ_MAX     7'h7F
`define IETS_SEQ_WRAP    7'h00

// Object indices
`define IETS_IX_STATE    16'h5430
`define IETS_IX_SEQ      16'h5431
`define IETS_IX_TS       16'h5432
`define IETS_IX_SLOT     16'h6000

// Output process area size
`define IETS_OUT_BYTES   8'h00

`endif

// ### design/iets_pkg.sv
`include "iets_defines.svh"
`default_nettype none

package iets_pkg;

  typedef enum logic {
    IETS_AREA_SMALL,
    IETS_AREA_LARGE
  } iets_area_t;

  typedef struct packed {
    logic [3:0]  state;
    logic [6:0]  seq;
    logic [15:0] ts;
  } iets_entry_t;

endpackage

`default_nettype wire

// ### design/iets_tmr_if.sv
`default_nettype none

interface iets_tmr_if;
  logic        us_tick;
  logic [31:0] us_count;
  modport src (output us_tick, output us_count);
  modport snk (input us_tick, input us_count);
endinterface

`default_nettype wire

// ### design/iets_us_timer.sv
`include "iets_defines.svh"
`default_nettype none

module iets_us_timer
  import iets_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `IETS_US_CYCLES
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_nrst,
  // Timer toward the capture logic
  iets_tmr_if.src   tmr
);

  localparam int unsigned PW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

  logic [PW-1:0] pre_r;
  logic [PW-1:0] pre_nxt;
  logic          tick;
  logic [31:0]   cnt_nxt;

  assign tick    = (pre_r == PW'(TICK_CYCLES - 1));
  assign pre_nxt = tick ? '0 : pre_r + 1'b1;
  assign cnt_nxt = (tmr.us_count == 32'hFFFF_FFFF) ? 32'h0000_0000
                                                    : tmr.us_count + 1'b1;
  assign tmr.us_tick = tick;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pre_r        <= '0;
      tmr.us_count <= 32'h0000_0000;
    end else begin
      pre_r <= pre_nxt;
      if (tick) begin
        tmr.us_count <= cnt_nxt;
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  property p_tmr_step;
    tick |=> tmr.us_count == $past(tmr.us_count) + 32'h0000_0001;
  endproperty
  a_tmr_step: assert property (p_tmr_step)
    else $error("timer did not step on tick");

  property p_tmr_hold;
    !tick |=> tmr.us_count == $past(tmr.us_count);
  endproperty
  a_tmr_hold: assert property (p_tmr_hold)
    else $error("timer moved without tick");

  property p_tmr_wrap;
    tick && tmr.us_count == 32'hFFFF_FFFF |=> tmr.us_count == 32'h0000_0000;
  endproperty
  a_tmr_wrap: assert property (p_tmr_wrap)
    else $error("timer did not wrap to zero");

endmodule

`default_nettype wire

// ### design/iets_capture.sv
`include "iets_defines.svh"
`default_nettype none

// Contract
// - Configured edge stores timer and inputs
// - Area holds 5 or 15 entries
// - Each entry takes four bytes
// - Byte 0 state, 1 number, 2-3 time
// - State byte shows levels after edge
// - Bits 0-3 inputs, bits 4-7 zero
// - Number runs 0..127, first is 1
// - Numbers follow edge order
// - 32-bit microsecond timer from zero
// - Timer wraps to zero at maximum
// - Stamp is timer low 16 bits
// - No output area bytes used
// - Index 5430h+field, subindex selects entry
// - Index 6000h+slot, subindex per field
// - Green channel light follows input
// - Red light on module error
module iets_capture
  import iets_pkg::*;
#(
  parameter int unsigned N_MAX = `IETS_N_LARGE
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // Input pins
  input  wire logic [3:0]  i_din,
  // Configuration
  input  wire logic        i_ets_en,
  input  wire logic [3:0]  i_rise_en,
  input  wire logic [3:0]  i_fall_en,
  input  wire logic        i_area_large,
  input  wire logic [7:0]  i_slot,
  input  wire logic        i_mod_error,
  // Process image byte read
  input  wire logic [5:0]  i_img_addr,
  output logic      [7:0]  o_img_data,
  // Object read
  input  wire logic [15:0] i_obj_index,
  input  wire logic [7:0]  i_obj_sub,
  output logic      [15:0] o_obj_data,
  output logic             o_obj_hit,
  // Status
  output logic      [3:0]  o_led_din,
  output logic             o_led_fault,
  output logic             o_capture,
  output logic      [7:0]  o_out_bytes
);

  iets_tmr_if tmr_if ();

  iets_us_timer u_tmr (
    .i_clk  (i_clk),
    .i_nrst (i_nrst),
    .tmr    (tmr_if)
  );

  logic [3:0]  din_m_r;
  logic [3:0]  din_s_r;
  logic [3:0]  din_d_r;
  iets_entry_t ent_r [N_MAX];
  logic [3:0]  ptr_r;
  logic [6:0]  seq_r;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      din_m_r <= 4'h0;
      din_s_r <= 4'h0;
      din_d_r <= 4'h0;
    end else begin
      din_m_r <= i_din;
      din_s_r <= din_m_r;
      din_d_r <= din_s_r;
    end
  end

  // arm after pipeline fill
  // A pin already high at reset must not look like a rising edge
  logic [2:0] arm_r;
  logic       armed;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      arm_r <= 3'h0;
    end else begin
      arm_r <= {arm_r[1:0], 1'b1};
    end
  end

  assign armed = arm_r[2];

  iets_area_t area;
  logic [3:0] n_ent;
  logic [3:0] last_ptr;
  logic [3:0] rise;
  logic [3:0] fall;
  logic [3:0] edge_hit;
  logic       cap;
  logic [3:0] ptr_nxt;
  logic [6:0] seq_nxt;

  assign area     = i_area_large ? IETS_AREA_LARGE : IETS_AREA_SMALL;
  assign n_ent    = (area == IETS_AREA_LARGE) ? 4'(`IETS_N_LARGE)
                                              : 4'(`IETS_N_SMALL);
  assign last_ptr = n_ent - 4'h1;
  assign rise     = din_s_r & ~din_d_r;
  assign fall     = ~din_s_r & din_d_r;
  assign edge_hit = (rise & i_rise_en) | (fall & i_fall_en);
  assign cap      = i_ets_en & armed & (|edge_hit);
  assign ptr_nxt  = (ptr_r >= last_ptr) ? 4'h0 : ptr_r + 4'h1;
  assign seq_nxt  = (seq_r == `IETS_SEQ_MAX) ? `IETS_SEQ_WRAP
                                             : seq_r + 7'h01;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ptr_r <= 4'h0;
      seq_r <= `IETS_SEQ_FIRST;
    end else if (cap) begin
      ptr_r <= ptr_nxt;
      seq_r <= seq_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < N_MAX; i++) begin
        ent_r[i] <= '0;
      end
    end else if (cap) begin
      ent_r[ptr_r].state <= din_s_r;
      ent_r[ptr_r].seq   <= seq_r;
      ent_r[ptr_r].ts    <= tmr_if.us_count[15:0];
    end
  end

  logic [3:0]  rd_ent;
  logic [1:0]  rd_ofs;
  logic        rd_ok;
  iets_entry_t rd_e;
  logic [7:0]  rd_byte;

  assign rd_ent  = i_img_addr[5:2];
  assign rd_ofs  = i_img_addr[1:0];
  assign rd_ok   = rd_ent < n_ent;
  assign rd_e    = rd_ok ? ent_r[rd_ent] : '0;
  assign rd_byte = (rd_ofs == `IETS_OFS_STATE) ? {4'h0, rd_e.state} :
                   (rd_ofs == `IETS_OFS_SEQ)   ? {1'b0, rd_e.seq}   :
                   (rd_ofs == `IETS_OFS_TS_LO) ? rd_e.ts[7:0]       :
                                                 rd_e.ts[15:8];

  logic [15:0] slot_ix;
  logic        obj_hit;
  logic [15:0] obj_val;
  logic        co_hit;
  logic        ec_hit;

  assign slot_ix = `IETS_IX_SLOT + {8'h00, i_slot};

  always_comb begin
    obj_hit = 1'b0;
    obj_val = 16'h0000;
    co_hit  = 1'b0;
    ec_hit  = 1'b0;
    for (int e = 0; e < N_MAX; e++) begin
      for (int f = 0; f < `IETS_N_FIELDS; f++) begin
        co_hit = (i_obj_index == 16'(`IETS_IX_STATE + f))
               && (i_obj_sub == 8'(e + 1));
        ec_hit = (i_obj_index == slot_ix)
               && (i_obj_sub == 8'(`IETS_N_FIELDS * e + f + 1));
        if ((4'(e) < n_ent) && (co_hit || ec_hit)) begin
          obj_hit = 1'b1;
          obj_val = (f == 0) ? {12'h000, ent_r[e].state} :
                    (f == 1) ? {9'h000, ent_r[e].seq}    :
                               ent_r[e].ts;
        end
      end
    end
  end

  assign o_out_bytes = `IETS_OUT_BYTES;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_img_data <= 8'h00;
      o_obj_data <= 16'h0000;
      o_obj_hit  <= 1'b0;
      o_capture  <= 1'b0;
    end else begin
      o_img_data <= rd_byte;
      o_obj_data <= obj_val;
      o_obj_hit  <= obj_hit;
      o_capture  <= cap;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_led_din   <= 4'h0;
      o_led_fault <= 1'b0;
    end else begin
      o_led_din   <= din_s_r;
      o_led_fault <= i_mod_error;
    end
  end

  // Helper state for the checks below
  logic [3:0] ptr_q;
  logic       seen_r;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ptr_q  <= 4'h0;
      seen_r <= 1'b0;
    end else begin
      ptr_q <= ptr_r;
      if (cap) begin
        seen_r <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  property p_cap_state;
    cap |=> ent_r[ptr_q].state == $past(din_s_r);
  endproperty
  a_cap_state: assert property (p_cap_state)
    else $error("captured state differs from inputs");

  property p_cap_edge;
    armed && i_ets_en && (rise & i_rise_en) != 4'h0 |-> ##1 o_capture;
  endproperty
  a_cap_edge: assert property (p_cap_edge)
    else $error("enabled rising edge not captured");

  property p_ts_low;
    cap |=> ent_r[ptr_q].ts == $past(tmr_if.us_count[15:0]);
  endproperty
  a_ts_low: assert property (p_ts_low)
    else $error("stamp is not timer low word");

  property p_seq_first;
    !seen_r |-> seq_r == `IETS_SEQ_FIRST;
  endproperty
  a_seq_first: assert property (p_seq_first)
    else $error("first number is not one");

  property p_seq_order;
    cap && seq_r != `IETS_SEQ_MAX |=>
      ent_r[ptr_q].seq == $past(seq_r) && seq_r == $past(seq_r) + 7'h01;
  endproperty
  a_seq_order: assert property (p_seq_order)
    else $error("numbers out of order");

  property p_seq_wrap;
    cap && seq_r == `IETS_SEQ_MAX |=> seq_r == `IETS_SEQ_WRAP;
  endproperty
  a_seq_wrap: assert property (p_seq_wrap)
    else $error("number did not wrap to zero");

  property p_ptr_wrap;
    cap && ptr_r == last_ptr |=> ptr_r == 4'h0;
  endproperty
  a_ptr_wrap: assert property (p_ptr_wrap)
    else $error("slot pointer did not wrap");

  property p_ptr_range;
    cap ##1 $stable(i_area_large) |-> ptr_r < n_ent;
  endproperty
  a_ptr_range: assert property (p_ptr_range)
    else $error("slot pointer beyond area");

  property p_nibble_zero;
    $past(rd_ofs) == `IETS_OFS_STATE |-> o_img_data[7:4] == 4'h0;
  endproperty
  a_nibble_zero: assert property (p_nibble_zero)
    else $error("state byte upper bits not zero");

  property p_led_din;
    $stable(din_s_r) [*2] |-> o_led_din == din_s_r;
  endproperty
  a_led_din: assert property (p_led_din)
    else $error("channel light disagrees with input");

  property p_led_fault;
    ##1 o_led_fault == $past(i_mod_error);
  endproperty
  a_led_fault: assert property (p_led_fault)
    else $error("fault light disagrees with error");

  property p_ptr_step;
    cap && ptr_r < last_ptr |=> ptr_r == $past(ptr_r) + 4'h1;
  endproperty
  a_ptr_step: assert property (p_ptr_step)
    else $error("entries not written one after another");

  property p_no_cap_off;
    !i_ets_en |=> !o_capture;
  endproperty
  a_no_cap_off: assert property (p_no_cap_off)
    else $error("capture while stamping is off");

  property p_rd_beyond;
    !rd_ok |=> o_img_data == 8'h00;
  endproperty
  a_rd_beyond: assert property (p_rd_beyond)
    else $error("byte beyond the area not zero");

  property p_obj_miss;
    !obj_hit |=> !o_obj_hit && o_obj_data == 16'h0000;
  endproperty
  a_obj_miss: assert property (p_obj_miss)
    else $error("object miss returned data");

  property p_sync_stage;
    ##1 din_s_r == $past(din_m_r);
  endproperty
  a_sync_stage: assert property (p_sync_stage)
    else $error("synchroniser stage skipped");

  c_small_wrap: cover property (cap && !i_area_large && ptr_r == 4'h4);
  c_large_wrap: cover property (cap && i_area_large && ptr_r == 4'hE);
  c_seq_wrap: cover property (cap && seq_r == `IETS_SEQ_MAX);
  c_obj_hit: cover property (o_obj_hit && i_obj_index == slot_ix);

endmodule

`default_nettype wire

// ### tb/iets_host_model.sv
`default_nettype none

module iets_host_model (
  // Clock
  input  wire logic        i_clk,
  // Process image byte read
  output logic      [5:0]  o_img_addr,
  input  wire logic [7:0]  i_img_data,
  // Object read
  output logic      [15:0] o_obj_index,
  output logic      [7:0]  o_obj_sub,
  input  wire logic [15:0] i_obj_data,
  input  wire logic        i_obj_hit
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_img_addr  = 6'h00;
    o_obj_index = 16'h0000;
    o_obj_sub   = 8'h00;
  end

  task automatic rd_byte(input logic [5:0] a, output logic [7:0] d);
    o_img_addr = a;
    @(negedge i_clk);
    d = i_img_data;
  endtask

  task automatic rd_obj(input logic [15:0] ix, input logic [7:0] sx,
                        output logic [15:0] d, output logic h);
    o_obj_index = ix;
    o_obj_sub   = sx;
    @(negedge i_clk);
    d = i_obj_data;
    h = i_obj_hit;
  endtask
endmodule

`default_nettype wire

// ### tb/input_edge_timestamp_capture_test.sv
`default_nettype none

module input_edge_timestamp_capture_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        nrst;
  logic [3:0]  din;
  logic        ets_en;
  logic [3:0]  rise_en;
  logic [3:0]  fall_en;
  logic        area_large;
  logic        mod_error;
  logic [5:0]  img_addr;
  logic [7:0]  img_data;
  logic [15:0] obj_index;
  logic [7:0]  obj_sub;
  logic [15:0] obj_data;
  logic        obj_hit;
  logic [3:0]  led_din;
  logic        led_fault;
  logic        capture;
  logic [7:0]  out_bytes;
  int          error_cnt;
  int          n_checks;
  int          cap_cnt;
  int          cycles;
  int          ptr;
  int          nent;
  logic [3:0]  exp_st [15];
  logic [6:0]  exp_sq [15];
  logic [6:0]  seqn;
  logic [7:0]  rb;
  logic [7:0]  rb2;
  logic [15:0] ro;
  logic        rh;
  logic [15:0] ts0;
  logic [7:0]  slot;

  iets_capture i_iets_capture (
    .i_clk(clk), .i_nrst(nrst), .i_din(din), .i_ets_en(ets_en),
    .i_rise_en(rise_en), .i_fall_en(fall_en), .i_area_large(area_large),
    .i_slot(slot), .i_mod_error(mod_error), .i_img_addr(img_addr),
    .o_img_data(img_data), .i_obj_index(obj_index), .i_obj_sub(obj_sub),
    .o_obj_data(obj_data), .o_obj_hit(obj_hit), .o_led_din(led_din),
    .o_led_fault(led_fault), .o_capture(capture), .o_out_bytes(out_bytes)
  );

  iets_host_model i_iets_host_model (
    .i_clk(clk), .o_img_addr(img_addr), .i_img_data(img_data),
    .o_obj_index(obj_index), .o_obj_sub(obj_sub),
    .i_obj_data(obj_data), .i_obj_hit(obj_hit)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (capture === 1'b1) begin
      cap_cnt++;
    end
    cycles++;
    if (cycles == 10000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Drive pins at a falling edge and track the expected entry
  task automatic edge_to(input logic [3:0] v);
    logic [3:0] hit;
    hit = (v & ~din & rise_en) | (~v & din & fall_en);
    din = v;
    repeat (5) @(negedge clk);
    if (ets_en && hit != 4'h0) begin
      exp_st[ptr] = v;
      exp_sq[ptr] = seqn;
      seqn        = seqn + 7'h01;
      ptr         = (ptr + 1 >= nent) ? 0 : ptr + 1;
    end
  endtask

  task automatic chk_entry(input int k);
    i_iets_host_model.rd_byte(6'(4 * k), rb);
    chk({8'h00, rb}, {12'h000, exp_st[k]});
    i_iets_host_model.rd_byte(6'(4 * k + 1), rb);
    chk({8'h00, rb}, {9'h000, exp_sq[k]});
    i_iets_host_model.rd_obj(16'h5430, 8'(k + 1), ro, rh);
    chk(ro, {12'h000, exp_st[k]});
    chk({15'h0000, rh}, 16'h0001);
    i_iets_host_model.rd_obj(16'h6000 + {8'h00, slot}, 8'(3 * k + 2), ro, rh);
    chk(ro, {9'h000, exp_sq[k]});
  endtask

  initial begin
    error_cnt = 0;
    n_checks = 0;
    cap_cnt = 0;
    cycles = 0;
    nrst = 1'b0;
    din = 4'h0;
    ets_en = 1'b0;
    rise_en = 4'hf;
    fall_en = 4'hf;
    area_large = 1'b0;
    slot = 8'h03;
    mod_error = 1'b0;
    ptr = 0;
    nent = 5;
    seqn = 7'h01;
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    chk({8'h00, out_bytes}, 16'h0000);
    i_iets_host_model.rd_byte(6'h01, rb);
    chk({8'h00, rb}, 16'h0000);
    // Lights follow pins and error status
    mod_error = 1'b1;
    edge_to(4'ha);
    chk({12'h000, led_din}, 16'h000a);
    chk({15'h0000, led_fault}, 16'h0001);
    mod_error = 1'b0;
    chk(16'(cap_cnt), 16'h0000);
    // Six captures wrap the five-entry area
    ets_en = 1'b1;
    for (int i = 0; i < 6; i++) begin
      edge_to(din ^ 4'(1 << (i % 4)));
    end
    chk(16'(cap_cnt), 16'h0006);
    chk({15'h0000, led_fault}, 16'h0000);
    for (int k = 0; k < 5; k++) begin
      chk_entry(k);
    end
    i_iets_host_model.rd_byte(6'h14, rb);
    chk({8'h00, rb}, 16'h0000);
    i_iets_host_model.rd_obj(16'h5430, 8'h06, ro, rh);
    chk({15'h0000, rh}, 16'h0000);
    // Disabled edges give no entry
    fall_en = 4'h0;
    edge_to(4'h0);
    ets_en = 1'b0;
    edge_to(4'hf);
    chk(16'(cap_cnt), 16'h0006);
    ets_en = 1'b1;
    fall_en = 4'hf;
    // Large area, stamps 1000 cycles apart
    area_large = 1'b1;
    nent = 15;
    edge_to(4'h0);
    i_iets_host_model.rd_byte(6'(4 * ptr - 2), rb);
    i_iets_host_model.rd_byte(6'(4 * ptr - 1), rb2);
    ts0 = {rb2, rb};
    chk(ts0, 16'h0000);
    repeat (993) @(negedge clk);
    edge_to(4'hb);
    i_iets_host_model.rd_byte(6'(4 * ptr - 2), rb);
    i_iets_host_model.rd_byte(6'(4 * ptr - 1), rb2);
    chk({rb2, rb} - ts0, 16'h000a);
    // Run the sequence number past 127
    for (int i = 0; i < 130; i++) begin
      edge_to(~din);
    end
    chk(16'(cap_cnt), 16'h008A);
    slot = 8'h21;
    for (int k = 0; k < 15; k++) begin
      chk_entry(k);
    end
    // Mid-run reset with a pin high: no false edge, fresh numbering
    nrst = 1'b0;
    @(negedge clk);
    nrst = 1'b1;
    i_iets_host_model.rd_byte(6'h01, rb);
    chk({8'h00, rb}, 16'h0000);
    ptr = 0;
    seqn = 7'h01;
    edge_to(~din);
    chk(16'(cap_cnt), 16'h008B);
    chk_entry(0);
    i_iets_host_model.rd_byte(6'h02, rb);
    i_iets_host_model.rd_byte(6'h03, rb2);
    chk({rb2, rb}, 16'h0000);
    report_and_stop();
  end
endmodule

`default_nettype wire
